// *** hw/dpsg_gpio.sv ***
// Two 8-bit GPIO ports with LCD segment sharing, reached over APB.
`timescale 1ns/1ps
module dpsg_gpio (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe_n,
  input wire logic [7:0] p1_pin_in,
  output logic [7:0] p1_pin_out,
  output logic [7:0] p1_pin_oe_n,
  input wire logic [7:0] p0_seg_data,
  input wire logic [7:0] p1_seg_data,
  input wire logic uart_txd,
  input wire logic sio_so,
  input wire logic sio_sck_out,
  output logic uart_rxd,
  output logic sio_si,
  output logic sio_sck_in,
  output logic uart_on_port0,
  output logic sio_on_port0
);
  function automatic logic reg_hit(input logic [15:0] addr, input logic [11:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (addr[15:2] == {2'h0, idx});
  endfunction : reg_hit

  logic [7:0] p0_latch_r;
  logic [7:0] p0_dir_r;
  logic [7:0] p0_seg_r;
  logic [7:0] p1_latch_r;
  logic [7:0] p1_dir_r;
  logic [7:0] p1_seg_r;
  logic [1:0] pin_group_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [7:0] p0_rd;
  logic [7:0] p1_rd;
  logic [7:0] p0_alt_en;
  logic [7:0] p0_alt_val;

  wire logic hit_p0_latch = reg_hit(paddr, dpsg_pkg::IDX_P0_LATCH);
  wire logic hit_p1_latch = reg_hit(paddr, dpsg_pkg::IDX_P1_LATCH);
  wire logic hit_p0_dir = reg_hit(paddr, dpsg_pkg::IDX_P0_DIR);
  wire logic hit_p1_dir = reg_hit(paddr, dpsg_pkg::IDX_P1_DIR);
  wire logic hit_p0_seg = reg_hit(paddr, dpsg_pkg::IDX_P0_SEG);
  wire logic hit_p1_seg = reg_hit(paddr, dpsg_pkg::IDX_P1_SEG);
  wire logic hit_group = reg_hit(paddr, dpsg_pkg::IDX_PIN_GROUP);
  wire logic hit_any = hit_p0_latch | hit_p1_latch | hit_p0_dir | hit_p1_dir
    | hit_p0_seg | hit_p1_seg | hit_group;
  wire logic setup_ph = psel & ~penable;
  wire logic access_ph = psel & penable;
  // Only lane 0 holds data; writes with pstrb[0] low change nothing.
  wire logic wr_ok = access_ph & pwrite & hit_any & pstrb[0];
  wire logic [7:0] wbyte = pwdata[7:0];

  // Read data is sampled during setup so it leaves a flip-flop in the access cycle.
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata = prdata_r;

  wire logic uart_here = ~pin_group_r[dpsg_pkg::UART_PIN_GROUP_BIT];
  wire logic sio_here = ~pin_group_r[dpsg_pkg::SERIAL_PIN_GROUP_BIT];
  assign uart_on_port0 = uart_here;
  assign sio_on_port0 = sio_here;
  // Inputs routed elsewhere idle high so a parked receiver sees no start bit.
  assign uart_rxd = uart_here ? p0_pin_in[dpsg_pkg::P0_UART_RXD] : 1'b1;
  assign sio_si = sio_here ? p0_pin_in[dpsg_pkg::P0_SIO_SI] : 1'b1;
  assign sio_sck_in = sio_here ? p0_pin_in[dpsg_pkg::P0_SIO_SCK] : 1'b1;

  always_comb begin
    p0_alt_en = 8'h00;
    p0_alt_val = 8'hFF;
    p0_alt_en[dpsg_pkg::P0_UART_TXD] = uart_here;
    p0_alt_val[dpsg_pkg::P0_UART_TXD] = uart_txd;
    p0_alt_en[dpsg_pkg::P0_SIO_SO] = sio_here;
    p0_alt_val[dpsg_pkg::P0_SIO_SO] = sio_so;
    p0_alt_en[dpsg_pkg::P0_SIO_SCK] = sio_here;
    p0_alt_val[dpsg_pkg::P0_SIO_SCK] = sio_sck_out;
  end

  dpsg_port_mux u_port0 (
    .clock(clock),
    .srst(srst),
    .latch(p0_latch_r),
    .dir(p0_dir_r),
    .seg_sel(p0_seg_r),
    .seg_data(p0_seg_data),
    .alt_en(p0_alt_en),
    .alt_val(p0_alt_val),
    .pin_in(p0_pin_in),
    .pin_out(p0_pin_out),
    .pin_oe_n(p0_pin_oe_n),
    .rd_val(p0_rd)
  );

  dpsg_port_mux u_port1 (
    .clock(clock),
    .srst(srst),
    .latch(p1_latch_r),
    .dir(p1_dir_r),
    .seg_sel(p1_seg_r),
    .seg_data(p1_seg_data),
    .alt_en(8'h00),
    .alt_val(8'hFF),
    .pin_in(p1_pin_in),
    .pin_out(p1_pin_out),
    .pin_oe_n(p1_pin_oe_n),
    .rd_val(p1_rd)
  );

  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_ph) begin
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_p0_latch) prdata_nxt[7:0] = p0_rd;
        if (hit_p1_latch) prdata_nxt[7:0] = p1_rd;
        if (hit_p0_dir) prdata_nxt[7:0] = p0_dir_r;
        if (hit_p1_dir) prdata_nxt[7:0] = p1_dir_r;
        if (hit_p0_seg) prdata_nxt[7:0] = p0_seg_r;
        if (hit_p1_seg) prdata_nxt[7:0] = p1_seg_r;
        if (hit_group) prdata_nxt[1:0] = pin_group_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      p0_latch_r <= dpsg_pkg::RST_LATCH;
      p0_dir_r <= dpsg_pkg::RST_DIR;
      p0_seg_r <= dpsg_pkg::RST_SEG;
    end else begin
      if (wr_ok && hit_p0_latch) p0_latch_r <= wbyte;
      if (wr_ok && hit_p0_dir) p0_dir_r <= wbyte;
      if (wr_ok && hit_p0_seg) p0_seg_r <= wbyte;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      p1_latch_r <= dpsg_pkg::RST_LATCH;
      p1_dir_r <= dpsg_pkg::RST_DIR;
      p1_seg_r <= dpsg_pkg::RST_SEG;
    end else begin
      if (wr_ok && hit_p1_latch) p1_latch_r <= wbyte;
      if (wr_ok && hit_p1_dir) p1_dir_r <= wbyte;
      if (wr_ok && hit_p1_seg) p1_seg_r <= wbyte;
    end
  end

  // Changing the pin group while a peripheral runs glitches its pins; nothing blocks it here.
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_group_r <= dpsg_pkg::RST_PIN_GROUP;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_ok && hit_group) pin_group_r <= wbyte[1:0];
      prdata_r <= prdata_nxt;
    end
  end

  a_p0_reset_clear: assert property (@(posedge clock)
    srst |=> (p0_latch_r == 8'h00 && p0_dir_r == 8'h00 && p0_seg_r == 8'h00
      && p0_pin_oe_n == 8'hFF))
    else $error("port 0 not cleared by reset");
  a_p1_reset_clear: assert property (@(posedge clock)
    srst |=> (p1_latch_r == 8'h00 && p1_dir_r == 8'h00 && p1_seg_r == 8'h00
      && p1_pin_oe_n == 8'hFF))
    else $error("port 1 not cleared by reset");
  a_p0_read_pin: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && hit_p0_latch && p0_dir_r == 8'h00 && p0_seg_r == 8'h00)
      |=> (prdata == {24'h000000, $past(p0_pin_in)}))
    else $error("port 0 input read does not show pin level");
  a_p0_read_zero: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && hit_p0_latch && p0_dir_r == 8'h00 && p0_seg_r == 8'hFF)
      |=> (prdata == 32'h0000_0000))
    else $error("port 0 segment input read not zero");
  a_p0_read_latch: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && hit_p0_latch && p0_dir_r == 8'hFF)
      |=> (prdata[7:0] == $past(p0_latch_r)))
    else $error("port 0 output read not latch");
  a_p1_read_pin: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && hit_p1_latch && p1_dir_r == 8'h00 && p1_seg_r == 8'h00)
      |=> (prdata[7:0] == $past(p1_pin_in)))
    else $error("port 1 input read does not show pin level");
  a_p1_read_zero: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && hit_p1_latch && p1_dir_r == 8'h00 && p1_seg_r == 8'hFF)
      |=> (prdata[7:0] == 8'h00))
    else $error("port 1 segment input read not zero");
  a_p1_read_latch: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && hit_p1_latch && p1_dir_r == 8'hFF)
      |=> (prdata[7:0] == $past(p1_latch_r)))
    else $error("port 1 output read not latch");
  a_p1_seg_drive: assert property (@(posedge clock) disable iff (srst)
    (p1_seg_r == 8'hFF) |-> (p1_pin_oe_n == 8'h00 && p1_pin_out == p1_seg_data))
    else $error("port 1 segment pins not driven");
  a_uart_route: assert property (@(posedge clock) disable iff (srst)
    (wr_ok && hit_group && pwdata[0]) |=> (!uart_on_port0 && uart_rxd))
    else $error("uart not moved off port 0");
  a_latch_write: assert property (@(posedge clock) disable iff (srst)
    (wr_ok && hit_p1_latch) |=> (p1_latch_r == $past(pwdata[7:0])))
    else $error("port 1 latch write lost");
endmodule : dpsg_gpio

// *** hw/dpsg_pkg.sv ***
// Package with register map, field positions and reset values of the dual port GPIO block.
package dpsg_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int IDX_W = 12;
  // Register indices; the byte address of each register is four times its index.
  localparam logic [IDX_W-1:0] IDX_P0_LATCH = 12'h000;
  localparam logic [IDX_W-1:0] IDX_P1_LATCH = 12'h001;
  localparam logic [IDX_W-1:0] IDX_P0_DIR = 12'h010;
  localparam logic [IDX_W-1:0] IDX_P1_DIR = 12'h011;
  localparam logic [IDX_W-1:0] IDX_P0_SEG = 12'hFAC;
  localparam logic [IDX_W-1:0] IDX_P1_SEG = 12'hFAD;
  localparam logic [IDX_W-1:0] IDX_PIN_GROUP = 12'hFBB;
  // Reset values.
  localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
  localparam logic [PORT_W-1:0] RST_SEG = 8'h00;
  localparam logic [1:0] RST_PIN_GROUP = 2'h0;
  // Fields of the pin group select register.
  localparam int UART_PIN_GROUP_BIT = 0;
  localparam int SERIAL_PIN_GROUP_BIT = 1;
  // Port 0 pin positions of the shared peripheral functions.
  localparam int P0_UART_RXD = 0;
  localparam int P0_UART_TXD = 1;
  localparam int P0_SIO_SI = 5;
  localparam int P0_SIO_SO = 6;
  localparam int P0_SIO_SCK = 7;
endpackage : dpsg_pkg

// *** hw/dpsg_port_mux.sv ***
// One 8-bit port: pin drive selection and data register read-back.
`timescale 1ns/1ps
module dpsg_port_mux (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] seg_sel,
  input wire logic [7:0] seg_data,
  input wire logic [7:0] alt_en,
  input wire logic [7:0] alt_val,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] rd_val
);
  for (genvar i = 0; i < 8; i++) begin : g_bit
    wire logic drv_port;
    wire logic port_val;
    assign drv_port = dir[i] & ~seg_sel[i];
    // A peripheral output is gated by the latch, so the latch must stay one while it is in use.
    assign port_val = alt_en[i] ? (alt_val[i] & latch[i]) : latch[i];
    assign pin_out[i] = seg_sel[i] ? seg_data[i] : (drv_port & port_val);
    assign pin_oe_n[i] = ~(seg_sel[i] | dir[i]);
    // Input-mode bits return the pin (zero where the segment select is set), so a read-modify-write copies pin levels into latches.
    assign rd_val[i] = dir[i] ? latch[i] : (~seg_sel[i] & pin_in[i]);

    a_seg_drive: assert property (@(posedge clock) disable iff (srst)
      seg_sel[i] |-> (!pin_oe_n[i] && pin_out[i] == seg_data[i]))
      else $error("segment pin not driven with segment data");
    a_alt_and: assert property (@(posedge clock) disable iff (srst)
      (dir[i] && !seg_sel[i] && alt_en[i]) |-> (pin_out[i] == (alt_val[i] & latch[i])))
      else $error("peripheral output not gated by latch");
    a_input_float: assert property (@(posedge clock) disable iff (srst)
      (!dir[i] && !seg_sel[i]) |-> pin_oe_n[i])
      else $error("input-mode pin is driven");
  end
endmodule : dpsg_port_mux

// *** bench/dpsg_pin_model.sv ***
// Pin-side model of the two ports: resolves each pad from the block's drive and an outside level.
`timescale 1ns/1ps
module dpsg_pin_model (
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe_n,
  input wire logic [7:0] p0_ext,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p1_ext,
  output logic [7:0] p0_in,
  output logic [7:0] p1_in
);
  // An undriven pad takes the outside level, which the bench changes on every pass.
  // A stale level therefore cannot pass for a fresh read.
  assign p0_in = (p0_out & ~p0_oe_n) | (p0_ext & p0_oe_n);
  assign p1_in = (p1_out & ~p1_oe_n) | (p1_ext & p1_oe_n);
endmodule : dpsg_pin_model

// *** bench/testbench.sv ***
// Self-checking bench of the dual port GPIO block with random register and pin traffic.
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h0000003A;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, uart_rxd, sio_si, sio_sck_in, uart_on_port0, sio_on_port0;
  logic uart_txd = 1'b1, sio_so = 1'b1, sio_sck_out = 1'b1;
  logic [7:0] p0_in, p1_in, p0_out, p1_out, p0_oe_n, p1_oe_n;
  logic [7:0] p0_ext = 8'h00, p1_ext = 8'h00, p0_seg = 8'h00, p1_seg = 8'h00;
  logic [11:0] tbl [6] = '{dpsg_pkg::IDX_P0_LATCH, dpsg_pkg::IDX_P0_DIR, dpsg_pkg::IDX_P0_SEG,
    dpsg_pkg::IDX_P1_LATCH, dpsg_pkg::IDX_P1_DIR, dpsg_pkg::IDX_P1_SEG};
  int bad_count = 0, samples_checked = 0, cycles = 0;

  dpsg_gpio dpsg_gpio_i (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p0_pin_in(p0_in), .p0_pin_out(p0_out),
    .p0_pin_oe_n(p0_oe_n), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe_n(p1_oe_n),
    .p0_seg_data(p0_seg), .p1_seg_data(p1_seg), .uart_txd(uart_txd), .sio_so(sio_so),
    .sio_sck_out(sio_sck_out), .uart_rxd(uart_rxd), .sio_si(sio_si), .sio_sck_in(sio_sck_in),
    .uart_on_port0(uart_on_port0), .sio_on_port0(sio_on_port0));
  dpsg_pin_model dpsg_pin_model_i (.p0_out(p0_out), .p0_oe_n(p0_oe_n), .p0_ext(p0_ext),
    .p1_out(p1_out), .p1_oe_n(p1_oe_n), .p1_ext(p1_ext), .p0_in(p0_in), .p1_in(p1_in));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] exp_rd(input logic [7:0] l, d, s, pin);
    return {24'h000000, (d & l) | (~d & ~s & pin)};
  endfunction : exp_rd
  function automatic logic [31:0] exp_out(input logic [7:0] l, d, s, sd, per);
    return {24'h000000, (s & sd) | (~s & d & l & per)};
  endfunction : exp_out
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Entered just after a rising edge; leaves one idle edge so no signal is assigned twice at once.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, v};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] l, d, s, per, v;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    p0_ext <= 8'hA5;
    @(posedge clock);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, tbl[k], 8'h00);
      if (k % 3 != 0) chk("reset reg", 32'h00000000, rd);
    end
    apb(1'b0, tbl[0], 8'h00);
    chk("p0 pin read", 32'h000000A5, rd);
    chk("p0 oe_n", 32'h000000FF, {24'h000000, p0_oe_n});
    chk("uart rxd", 32'h00000001, {31'h0, uart_rxd});
    chk("sio si", 32'h00000001, {31'h0, sio_si});
    chk("uart routed", 32'h00000001, {31'h0, uart_on_port0});
    pstrb <= 4'hE;
    apb(1'b1, tbl[1], 8'hFF);
    pstrb <= 4'hF;
    apb(1'b0, tbl[1], 8'h00);
    chk("strobe off", 32'h00000000, rd);
    apb(1'b0, 12'h002, 8'h00);
    chk("unmapped err", 32'h00000001, {31'h0, err});
    chk("unmapped data", 32'h00000000, rd);
    for (int n = 0; n < 60; n++) begin
      for (int p = 0; p < 2; p++) begin
        l = 8'(rnd());
        d = 8'(rnd());
        s = 8'(rnd());
        v = 8'(rnd());
        if (p == 0) p0_ext <= v;
        else p1_ext <= v;
        v = 8'(rnd());
        if (p == 0) p0_seg <= v;
        else p1_seg <= v;
        {uart_txd, sio_so, sio_sck_out} <= v[7:5];
        apb(1'b1, tbl[p * 3], l);
        apb(1'b1, tbl[p * 3 + 1], d);
        apb(1'b1, tbl[p * 3 + 2], s);
        apb(1'b0, tbl[p * 3 + 1], 8'h00);
        chk("dir", {24'h000000, d}, rd);
        apb(1'b0, tbl[p * 3 + 2], 8'h00);
        chk("seg", {24'h000000, s}, rd);
        apb(1'b0, tbl[p * 3], 8'h00);
        chk("data", exp_rd(l, d, s, p ? p1_in : p0_in), rd);
        #1;
        per = p ? 8'hFF : {sio_sck_out, sio_so, 4'hF, uart_txd, 1'b1};
        chk("pin_out", exp_out(l, d, s, p ? p1_seg : p0_seg, per), p ? p1_out : p0_out);
        chk("oe_n", {24'h000000, ~(d | s)}, p ? p1_oe_n : p0_oe_n);
        @(posedge clock);
      end
    end
    v = 8'(rnd());
    p1_ext <= v;
    apb(1'b1, tbl[4], 8'h00);
    apb(1'b1, tbl[5], 8'h00);
    apb(1'b0, tbl[3], 8'h00);
    apb(1'b1, tbl[3], rd[7:0]);
    apb(1'b1, tbl[4], 8'hFF);
    apb(1'b0, tbl[3], 8'h00);
    chk("rmw latch", {24'h000000, v}, rd);
    // Peripheral output on port 0: latch and direction one, segment clear.
    apb(1'b1, tbl[0], 8'hFF);
    apb(1'b1, tbl[2], 8'h00);
    apb(1'b1, tbl[1], 8'hFF);
    uart_txd <= 1'b0;
    @(posedge clock);
    chk("txd low", 32'h00000000, {31'h0, p0_out[dpsg_pkg::P0_UART_TXD]});
    uart_txd <= 1'b1;
    @(posedge clock);
    chk("txd high", 32'h00000001, {31'h0, p0_out[dpsg_pkg::P0_UART_TXD]});
    // Input bits with every segment select set read zero, and segment pins carry segment data.
    apb(1'b1, tbl[1], 8'h00);
    apb(1'b1, tbl[2], 8'hFF);
    apb(1'b0, tbl[0], 8'h00);
    chk("p0 seg input read", 32'h00000000, rd);
    p1_seg <= 8'h3C;
    apb(1'b1, tbl[4], 8'h00);
    apb(1'b1, tbl[5], 8'hFF);
    chk("p1 seg pins", 32'h0000003C, {24'h000000, p1_out});
    chk("p1 seg oe_n", 32'h00000000, {24'h000000, p1_oe_n});
    apb(1'b0, tbl[3], 8'h00);
    chk("p1 seg input read", 32'h00000000, rd);
    // A second reset in mid-run must clear written registers again.
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk("p0 oe_n reset", 32'h000000FF, {24'h000000, p0_oe_n});
    chk("p1 oe_n reset", 32'h000000FF, {24'h000000, p1_oe_n});
    apb(1'b0, tbl[5], 8'h00);
    chk("p1 seg reset", 32'h00000000, rd);
    apb(1'b1, tbl[4], 8'hFF);
    apb(1'b0, tbl[3], 8'h00);
    chk("p1 latch reset", 32'h00000000, rd);
    apb(1'b1, dpsg_pkg::IDX_PIN_GROUP, 8'h03);
    apb(1'b0, dpsg_pkg::IDX_PIN_GROUP, 8'h00);
    chk("group reg", 32'h00000003, rd);
    chk("uart away", 32'h00000001, {31'h0, uart_rxd});
    chk("uart flag", 32'h00000000, {31'h0, uart_on_port0});
    chk("sio flag", 32'h00000000, {31'h0, sio_on_port0});
    chk("sck away", 32'h00000001, {31'h0, sio_sck_in});
    chk("si away", 32'h00000001, {31'h0, sio_si});
    print_verdict();
  end
endmodule : testbench
